/* File: rtl/spg_defines.svh */
`ifndef SPG_DEFINES_SVH
`define SPG_DEFINES_SVH

// ==========================================================
// register offsets (byte addresses, one word each)
`define SPG_OFS_CMD     8'h00
`define SPG_OFS_OPND    8'h04
`define SPG_OFS_STATUS  8'h08
`define SPG_OFS_RDATA   8'h0C

// ==========================================================
// field positions
`define SPG_CMD_CODE_LSB  0
`define SPG_CMD_HOLD_BIT  4
`define SPG_CMD_DISCH_BIT 5
`define SPG_ST_BUSY_BIT   0
`define SPG_ST_DONE_BIT   1
`define SPG_ST_REFUSE_BIT 2

// ==========================================================
// reset values
`define SPG_RST_CODE    4'h0
`define SPG_RST_OPND    16'h0000
`define SPG_RST_RDATA   16'h0000

// ==========================================================
// frame layout and commands
`define SPG_FRAME_BITS  20
`define SPG_CODE_BITS   4
`define SPG_IN_BITS     8
`define SPG_CODE_CORE   4'h0
`define SPG_CODE_SHOUT  4'h2

// ==========================================================
// timing
`define SPG_CLK_MHZ       40
`define SPG_HALF_CYC      4
`define SPG_T_TURN_NS     40
`define SPG_T_PROG_US     1000
`define SPG_T_DISCH_US    100
`define SPG_TURN_CYC      ((`SPG_T_TURN_NS * `SPG_CLK_MHZ + 999) / 1000)
`define SPG_PROG_CYC      (`SPG_T_PROG_US * `SPG_CLK_MHZ)
`define SPG_DISCH_CYC     (`SPG_T_DISCH_US * `SPG_CLK_MHZ)
`define SPG_TAIL_CYC      3

`endif

/* File: rtl/spg_pkg.sv */
package spg_pkg;

   // ==========================================================
   // frame engine states
   typedef enum logic [2:0] {
      SPG_IDLE  = 3'b000,
      SPG_LOW   = 3'b001,
      SPG_HIGH  = 3'b010,
      SPG_TURN  = 3'b011,
      SPG_TAIL  = 3'b100,
      SPG_DISCH = 3'b101
   } spg_state_type;

   // ==========================================================
   // one frame request as software set it up
   typedef struct packed {
      logic [3:0]  code;
      logic [15:0] operand;
      logic        hold_prog;
      logic        discharge;
   } spg_req_type;

endpackage : spg_pkg

/* File: rtl/spg_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spg_defines.svh"

// Operation
// - clock pin is driven here; data changes after rise, sampled at fall, LSB first
// - each frame is 4 code bits then 16 operand bits
// - software clears memory-select bits 7:6 before an EEPROM write
// - write-enable bit 2 must be set first; device refuses writes otherwise
// - write-start bit 1; device write begins on falling edge of 24th clock; the device model writes at the end of the second no-op frame
// - device clears write-start; software polls via table latch shift-out
// - after EEPROM write hold clock low for discharge time
// - ID programming loads only first 8 write buffer bytes
// - ID write: three 1101, one 1111, no-op with clock high then low
// - ID locations are erased before rewriting
// - table read returns byte LSB first in final 8 clocks
// - clock held low for turnaround after 8th operand clock on reads
// - pointer wraps past code memory; software reloads 200000h
// - first read of a protected block is discarded and repeated
// - code verify pairs two consecutive bytes into a word
// - configuration bytes are compared one at a time
module spg_host #(
   parameter int HALF_CYC  = `SPG_HALF_CYC,
   parameter int TURN_CYC  = `SPG_TURN_CYC,
   parameter int PROG_CYC  = `SPG_PROG_CYC,
   parameter int DISCH_CYC = `SPG_DISCH_CYC
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // programming pins
   output var  logic        prog_clk,
   output var  logic        prog_dat_o,
   output var  logic        prog_dat_oe,
   input  wire logic        prog_dat_i
);
   import spg_pkg::*;

   // ==========================================================
   // state
   spg_state_type state, next_state;
   spg_req_type   req, next_req;
   logic [23:0]   cnt, next_cnt;
   logic [4:0]    bit_idx, next_bit_idx;
   logic [19:0]   shift, next_shift;
   logic [7:0]    rx, next_rx;
   logic [15:0]   rdata, next_rdata;
   logic [1:0]    cap, next_cap;
   logic          done, next_done;
   logic          refused, next_refused;
   logic          next_prog_clk;
   logic          next_prog_dat_o;
   logic          next_prog_dat_oe;
   logic [31:0]   next_prdata;
   logic          din_s1;
   logic          din_s2;

   // ==========================================================
   // helpers
   logic        apb_wr;
   logic        apb_setup;
   logic        mapped;
   logic        is_read;
   logic        rx_bit;
   logic [23:0] high_lim;

   assign apb_wr    = psel & penable & pwrite;
   assign apb_setup = psel & ~penable;
   assign mapped    = (paddr == `SPG_OFS_CMD) | (paddr == `SPG_OFS_OPND) |
                      (paddr == `SPG_OFS_STATUS) | (paddr == `SPG_OFS_RDATA);
   // zero-wait slave: every access completes in its first access cycle
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~mapped;

   // 0010 and 10xx frames have 8 in-bits then 8 out-bits
   assign is_read   = (req.code == `SPG_CODE_SHOUT) | (req.code[3:2] == 2'b10);
   assign rx_bit    = is_read & (bit_idx >= 5'(`SPG_CODE_BITS + `SPG_IN_BITS));
   // the 4th clock of a frame may be stretched high for the program time
   assign high_lim  = (req.hold_prog && bit_idx == 5'd3) ? 24'(PROG_CYC - 1)
                                                         : 24'(HALF_CYC - 1);

   // ==========================================================
   // next values
   always_comb begin
      next_state       = state;
      next_req         = req;
      next_cnt         = cnt;
      next_bit_idx     = bit_idx;
      next_shift       = shift;
      next_rx          = rx;
      next_rdata       = rdata;
      next_cap         = {cap[0], 1'b0};
      next_done        = done;
      next_refused     = refused;
      next_prog_clk    = prog_clk;
      next_prog_dat_o  = prog_dat_o;
      next_prog_dat_oe = prog_dat_oe;
      next_prdata      = prdata;

      // register reads latched in setup so the data comes from flops
      if (apb_setup) begin
         unique case (paddr)
            `SPG_OFS_CMD:    next_prdata = {26'h0, req.discharge, req.hold_prog, req.code};
            `SPG_OFS_OPND:   next_prdata = {16'h0, req.operand};
            `SPG_OFS_STATUS: next_prdata = {26'h0, 3'(state), refused, done, state != SPG_IDLE};
            `SPG_OFS_RDATA:  next_prdata = {16'h0, rdata};
            default:         next_prdata = 32'h0;
         endcase
      end

      // sticky flags: write one to clear; a set below wins
      if (apb_wr && paddr == `SPG_OFS_STATUS) begin
         if (pwdata[`SPG_ST_DONE_BIT]) begin
            next_done = 1'b0;
         end
         if (pwdata[`SPG_ST_REFUSE_BIT]) begin
            next_refused = 1'b0;
         end
      end

      if (apb_wr && paddr == `SPG_OFS_OPND) begin
         if (state != SPG_IDLE) begin
            next_refused = 1'b1;
         end else begin
            next_req.operand = pwdata[15:0];
         end
      end

      // pointer, control and data set-up (including select bits, write enable,
      // ID base reload and erase) are plain core frames composed by software
      if (apb_wr && paddr == `SPG_OFS_CMD) begin
         if (state != SPG_IDLE) begin
            next_refused = 1'b1;
         end else begin
            next_req.code      = pwdata[`SPG_CMD_CODE_LSB +: 4];
            next_req.hold_prog = pwdata[`SPG_CMD_HOLD_BIT];
            next_req.discharge = pwdata[`SPG_CMD_DISCH_BIT];
            next_shift         = {req.operand, pwdata[`SPG_CMD_CODE_LSB +: 4]};
            next_bit_idx       = 5'd0;
            next_cnt           = 24'd0;
            next_state         = SPG_LOW;
         end
      end

      // received bits: sampled two cycles after our falling edge
      if (cap[1]) begin
         next_rx = {din_s2, rx[7:1]};
      end

      unique case (state)
         SPG_IDLE: begin
            next_prog_clk    = 1'b0;
            next_prog_dat_oe = 1'b0;
         end
         SPG_LOW: begin
            if (cnt >= 24'(HALF_CYC - 1)) begin
               next_cnt         = 24'd0;
               next_state       = SPG_HIGH;
               next_prog_clk    = 1'b1;
               // data changes right after the rising edge
               next_prog_dat_o  = shift[bit_idx];
               next_prog_dat_oe = ~rx_bit;
            end else begin
               next_cnt = cnt + 24'd1;
            end
         end
         SPG_HIGH: begin
            if (cnt >= high_lim) begin
               next_cnt      = 24'd0;
               next_prog_clk = 1'b0;
               next_bit_idx  = bit_idx + 5'd1;
               next_cap      = {cap[0], rx_bit};
               if (bit_idx == 5'(`SPG_FRAME_BITS - 1)) begin
                  next_state = SPG_TAIL;
               end else if (is_read && bit_idx == 5'(`SPG_CODE_BITS + `SPG_IN_BITS - 1)) begin
                  // release the pin and hold clock low for the turnaround
                  next_prog_dat_oe = 1'b0;
                  next_state       = SPG_TURN;
               end else begin
                  next_state = SPG_LOW;
               end
            end else begin
               next_cnt = cnt + 24'd1;
            end
         end
         SPG_TURN: begin
            if (cnt >= 24'(TURN_CYC - 1)) begin
               next_cnt   = 24'd0;
               next_state = SPG_LOW;
            end else begin
               next_cnt = cnt + 24'd1;
            end
         end
         SPG_TAIL: begin
            next_prog_dat_oe = 1'b0;
            if (cnt >= 24'(`SPG_TAIL_CYC)) begin
               next_cnt  = 24'd0;
               next_done = 1'b1;
               if (is_read) begin
                  // keep the previous byte above so two reads form a word
                  next_rdata = {rdata[7:0], rx};
               end
               next_state = req.discharge ? SPG_DISCH : SPG_IDLE;
            end else begin
               next_cnt = cnt + 24'd1;
            end
         end
         SPG_DISCH: begin
            // clock stays low so the array can discharge
            next_prog_clk = 1'b0;
            if (cnt >= 24'(DISCH_CYC - 1)) begin
               next_cnt   = 24'd0;
               next_state = SPG_IDLE;
            end else begin
               next_cnt = cnt + 24'd1;
            end
         end
         default: begin
            next_state = SPG_IDLE;
         end
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= SPG_IDLE;
         req         <= '{code: `SPG_RST_CODE, operand: `SPG_RST_OPND, hold_prog: 1'b0, discharge: 1'b0};
         cnt         <= 24'h000000;
         bit_idx     <= 5'h00;
         shift       <= 20'h00000;
         rx          <= 8'h00;
         rdata       <= `SPG_RST_RDATA;
         cap         <= 2'h0;
         done        <= 1'b0;
         refused     <= 1'b0;
         prog_clk    <= 1'b0;
         prog_dat_o  <= 1'b0;
         prog_dat_oe <= 1'b0;
         prdata      <= 32'h00000000;
         din_s1      <= 1'b0;
         din_s2      <= 1'b0;
      end else begin
         state       <= next_state;
         req         <= next_req;
         cnt         <= next_cnt;
         bit_idx     <= next_bit_idx;
         shift       <= next_shift;
         rx          <= next_rx;
         rdata       <= next_rdata;
         cap         <= next_cap;
         done        <= next_done;
         refused     <= next_refused;
         prog_clk    <= next_prog_clk;
         prog_dat_o  <= next_prog_dat_o;
         prog_dat_oe <= next_prog_dat_oe;
         prdata      <= next_prdata;
         din_s1      <= prog_dat_i;
         din_s2      <= din_s1;
      end
   end

endmodule : spg_host
`default_nettype wire

/* File: dv/spg_host_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module spg_host_monitor #(
   parameter int HALF_CYC = 4,
   parameter int TURN_CYC = 2
) (
   // clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // apb
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic [7:0] paddr,
   // programming pins
   input wire logic       prog_clk,
   input wire logic       prog_dat_o,
   input wire logic       prog_dat_oe
);
   // ======
   // helpers: rises in frame, frame code, low run
   logic [4:0] cnt, next_cnt;
   logic [3:0] code, next_code;
   logic [7:0] lo, next_lo;
   logic       clk_q, rise, rd, cmd_wr;
   assign rise = prog_clk & ~clk_q;
   assign rd = (code == 4'h2) || (code[3:2] == 2'b10);
   assign cmd_wr = psel && penable && pwrite && (paddr == 8'h00);
   always_comb begin
      next_cnt = cnt;
      next_code = code;
      next_lo = prog_clk ? 8'h00 : ((lo == 8'hFF) ? lo : lo + 8'h01);
      if (rise) begin
         next_cnt = (cnt == 5'd19) ? 5'd0 : cnt + 5'd1;
         if (cnt < 5'd4) next_code[cnt[1:0]] = prog_dat_o;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 5'd0;
         code <= 4'h0;
         lo <= 8'h00;
         clk_q <= 1'b0;
      end else begin
         cnt <= next_cnt;
         code <= next_code;
         lo <= next_lo;
         clk_q <= prog_clk;
      end
   end
   // ======
   // properties
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_high; prog_clk [*4]; endsequence
   property p_dat_moves; $changed(prog_dat_o) |-> $rose(prog_clk); endproperty
   property p_oe_rise; $rose(prog_dat_oe) |-> $rose(prog_clk); endproperty
   property p_high_len; $rose(prog_clk) |-> s_high; endproperty
   property p_low_len; $rose(prog_clk) |-> lo >= HALF_CYC; endproperty
   property p_frame_len; cmd_wr |-> cnt == 5'd0; endproperty
   property p_turn; $rose(prog_clk) && rd && cnt == 5'd12 |-> lo >= HALF_CYC + TURN_CYC; endproperty
   property p_drives; cnt != 5'd0 && (!rd || cnt <= 5'd11) |-> prog_dat_oe; endproperty
   property p_release; rd && cnt >= 5'd13 |-> !prog_dat_oe; endproperty
   a_dat_moves: assert property (p_dat_moves) else $error("data moved off a clock rise");
   a_oe_rise: assert property (p_oe_rise) else $error("drive began off a clock rise");
   a_high_len: assert property (p_high_len) else $error("clock high phase short");
   a_low_len: assert property (p_low_len) else $error("clock low phase short");
   a_frame_len: assert property (p_frame_len) else $error("frame not twenty clocks");
   a_turn: assert property (p_turn) else $error("turnaround low time short");
   a_drives: assert property (p_drives) else $error("host not driving its bits");
   a_release: assert property (p_release) else $error("host drives during read bits");
endmodule : spg_host_monitor
bind spg_host spg_host_monitor #(.HALF_CYC(HALF_CYC), .TURN_CYC(TURN_CYC)) u_mon (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .prog_clk, .prog_dat_o, .prog_dat_oe);
`default_nettype wire

/* File: dv/spg_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spg_dev_model (
   // clocks
   input wire logic pclk,
   input wire logic prog_clk,
   // data pin
   input wire logic host_oe,
   input wire logic host_o,
   output logic     pin
);
   // ======
   // serial core, no reset: device state is behavioural only
   logic [19:0] sh;
   logic [7:0]  w, latch, obyte;
   logic [21:0] ptr;
   logic        drv, dbit, tog, rdf;
   logic [7:0]  ctrl, eedat, ee_addr_lo, nops;
   logic [7:0]  mem [0:255];
   int          n;
   initial begin
      ctrl = 8'h00;
      nops = 8'h00;
      n = 0;
      drv = 0;
      tog = 0;
      ptr = 0;
   end
   // released pin wanders each cycle, no pull on this line
   always @(posedge pclk) tog <= ~tog;
   assign pin = host_oe ? host_o : (drv ? dbit : tog);
   assign rdf = (sh[3:0] == 4'h2) || (sh[3:2] == 2'b10);
   always @(posedge prog_clk) begin
      drv <= rdf && n >= 12;
      dbit <= obyte[(n + 4) % 8];
   end
   always @(negedge prog_clk) begin
      sh[n] = pin;
      n = n + 1;
      if (n == 4) obyte = (sh[3:0] == 4'h2) ? latch : (ptr[7:0] ^ 8'hC3);
      if (n == 20) begin
         n = 0;
         drv = 0;
         if (sh[3:0] == 4'h9) ptr = ptr + 22'd1;
         if (sh[3:0] == 4'h0 && sh[19:12] == 8'h0E) w = sh[11:4];
         if (sh[3:0] == 4'h0 && sh[19:12] == 8'h6E) begin
            case (sh[11:4])
               8'hF5: latch = w;
               8'hF6: ptr[7:0] = w;
               8'hF7: ptr[15:8] = w;
               8'hF8: ptr[21:16] = w[5:0];
               8'hA8: eedat = w;
               8'hA9: ee_addr_lo = w;
               default: ;
            endcase
         end
         // control register bit set/clear, copies into w
         if (sh[3:0] == 4'h0 && sh[19:16] == 4'h8 && sh[11:4] == 8'hA6) begin
            if (sh[15:13] != 3'd1 || ctrl[2]) ctrl[sh[15:13]] = 1'b1;
            if (sh[15:13] == 3'd1) nops = 8'h00;
            if (sh[15:13] == 3'd0 && ctrl[7:6] == 2'b00) eedat = mem[ee_addr_lo];
         end
         if (sh[3:0] == 4'h0 && sh[19:16] == 4'h9 && sh[11:4] == 8'hA6) ctrl[sh[15:13]] = 1'b0;
         if (sh[3:0] == 4'h0 && sh[19:4] == 16'h50A6) w = ctrl;
         if (sh[3:0] == 4'h0 && sh[19:4] == 16'h50A8) w = eedat;
         // write applied on the second no-op after write-start
         if (sh[3:0] == 4'h0 && sh[19:4] == 16'h0000 && ctrl[1]) begin
            nops = nops + 8'h01;
            if (nops == 8'h02) begin
               mem[ee_addr_lo] = 8'hFF;
               mem[ee_addr_lo] = eedat;
               ctrl[1] = 1'b0;
            end
         end
      end
   end
endmodule : spg_dev_model
`default_nettype wire

/* File: dv/spg_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module spg_host_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic        prog_clk, prog_dat_o, prog_dat_oe, pin;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [21:0] a;
   int          miscompares, n_compared, cyc, cyc_n, hi_run, hi_max;
   spg_host #(.HALF_CYC(4), .TURN_CYC(2), .PROG_CYC(20), .DISCH_CYC(10)) dut (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .prog_clk, .prog_dat_o, .prog_dat_oe,
      .prog_dat_i(pin));
   spg_dev_model dev (.pclk, .prog_clk, .host_oe(prog_dat_oe), .host_o(prog_dat_o), .pin);
   initial begin
      pclk = 0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) hi_run <= prog_clk ? hi_run + 1 : 0;
   always @(posedge pclk) if (hi_run > hi_max) hi_max <= hi_run;
   // ======
   // checks and bus tasks
   task automatic stop_test;
      $display("compared %0d, miscompared %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_min(input int got, input int least);
      n_compared++;
      if (got < least) begin
         miscompares++;
         $display("unexpected at %0t: %0d below %0d", $time, got, least);
      end
   endtask : chk_min
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
      int k;
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      for (k = 0; k < 50 && pready !== 1'b1; k++) @(posedge pclk);
      if (k == 50) begin
         miscompares++;
         stop_test();
      end
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   // ======
   // one frame: operand, command, poll busy away, clear sticky bits
   task automatic frame(input logic [5:0] c, input logic [15:0] op);
      time t0;
      logic [31:0] q;
      int k;
      apb(1, 8'h04, {16'h0, op}, q);
      apb(1, 8'h00, {26'h0, c}, q);
      t0 = $time;
      q = 32'h1;
      for (k = 0; k < 3000 && q[0] !== 1'b0; k++) apb(0, 8'h08, 32'h0, q);
      if (k == 3000) begin
         miscompares++;
         stop_test();
      end
      cyc = int'(($time - t0) / 25);
      chk(q & 32'h7, 32'h2);
      apb(1, 8'h08, 32'h6, q);
   endtask : frame
   task automatic set_ptr(input logic [21:0] p);
      frame(6'h00, {10'h038, p[21:16]});
      frame(6'h00, 16'h6EF8);
      frame(6'h00, {8'h0E, p[15:8]});
      frame(6'h00, 16'h6EF7);
      frame(6'h00, {8'h0E, p[7:0]});
      frame(6'h00, 16'h6EF6);
   endtask : set_ptr
   // ======
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, hi_run, hi_max} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      apb(0, 8'h08, 32'h0, rd);
      chk(rd, 32'h0);
      apb(0, 8'h0C, 32'h0, rd);
      chk(rd, 32'h0);
      apb(0, 8'h10, 32'h0, rd);
      chk({31'h0, e}, 32'h1);
      frame(6'h00, 16'h0E5A);
      frame(6'h00, 16'h6EF5);
      frame(6'h02, 16'h0000);
      apb(0, 8'h0C, 32'h0, rd);
      chk(rd[7:0], 8'h5A);
      for (int i = 0; i < 3; i++) begin
         a = (i == 0) ? 22'h200000 : ((i == 1) ? 22'h300000 : 22'h3FFFFF);
         set_ptr(a);
         frame(6'h09, 16'h0000);
         frame(6'h09, 16'h0000);
         apb(0, 8'h0C, 32'h0, rd);
         chk(rd[15:0], {a[7:0] ^ 8'hC3, 8'(a + 22'd1) ^ 8'hC3});
      end
      frame(6'h0D, 16'h1122);
      frame(6'h0D, 16'h3344);
      frame(6'h0D, 16'h5566);
      frame(6'h0F, 16'h7788);
      cyc_n = cyc;
      hi_max = 0;
      frame(6'h30, 16'h0000);
      chk_min(hi_max, 20);
      chk_min(cyc - cyc_n, 20);
      // eeprom: select, address 12h, data 3Ch
      frame(6'h00, 16'h9EA6);
      frame(6'h00, 16'h9CA6);
      frame(6'h00, 16'h0E12);
      frame(6'h00, 16'h6EA9);
      frame(6'h00, 16'h0E3C);
      frame(6'h00, 16'h6EA8);
      // write-start without write-enable must not stick
      frame(6'h00, 16'h82A6);
      frame(6'h00, 16'h50A6);
      frame(6'h00, 16'h6EF5);
      frame(6'h02, 16'h0000);
      apb(0, 8'h0C, 32'h0, rd);
      chk(rd[7:0] & 8'h02, 8'h00);
      frame(6'h00, 16'h84A6);
      frame(6'h00, 16'h82A6);
      frame(6'h00, 16'h0000);
      frame(6'h20, 16'h0000);
      frame(6'h00, 16'h50A6);
      frame(6'h00, 16'h6EF5);
      frame(6'h02, 16'h0000);
      apb(0, 8'h0C, 32'h0, rd);
      chk(rd[7:0] & 8'h02, 8'h00);
      frame(6'h00, 16'h94A6);
      // overwrite the data register, then read the byte back
      frame(6'h00, 16'h0E00);
      frame(6'h00, 16'h6EA8);
      frame(6'h00, 16'h80A6);
      frame(6'h00, 16'h50A8);
      frame(6'h00, 16'h6EF5);
      frame(6'h02, 16'h0000);
      apb(0, 8'h0C, 32'h0, rd);
      chk(rd[7:0], 8'h3C);
      stop_test();
   end
endmodule : spg_host_tb
`default_nettype wire
